// [rcp_parser.sv]
// remote ascii command parser: line buffer, decoder, executor handshake, reply sender
`timescale 1ns/1ps
`default_nettype none

module rcp_parser (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire rcp_pkg::rcp_rxch_type ser_rx_i,
  input wire rcp_pkg::rcp_rxch_type gpib_rx_i,
  output logic rx_ready_o,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  output logic tx_gpib_o,
  input wire logic tx_ready_i,
  output logic exec_valid_o,
  output rcp_pkg::rcp_cmd_type exec_cmd_o,
  input wire logic exec_done_i,
  input wire rcp_pkg::rcp_result_type exec_res_i
);
  typedef enum logic [1:0] {
    RCP_COLLECT,
    RCP_PARSE,
    RCP_EXEC,
    RCP_REPLY
  } rcp_state_type;

  rcp_state_type state_q, state_d;
  logic [7:0] buf_mem [rcp_pkg::RCP_BUF_DEPTH];
  logic [5:0] wr_q, rd_q;
  logic ovf_q, from_gpib_q, rx_ready_q;
  rcp_pkg::rcp_phase_type ph_q;
  logic [31:0] mn_q;
  logic [2:0] mn_cnt_q;
  logic err_q, last_q;
  rcp_pkg::rcp_cmd_type cmd_q;
  logic exec_valid_q;
  rcp_pkg::rcp_result_type res_q;
  logic [3:0] tx_idx_q;
  logic tx_valid_q;
  logic [7:0] tx_data_q;

  // receive side; gpib only wins when serial is quiet, both never talk at once
  wire logic use_ser = ser_rx_i.valid;
  wire logic rx_any = ser_rx_i.valid | gpib_rx_i.valid;
  wire logic rx_take = rx_ready_q & rx_any;
  wire logic [7:0] rx_char = use_ser ? ser_rx_i.data : gpib_rx_i.data;
  // serial has no flow lines, so eoi is honoured on gpib only
  wire logic rx_eoi = ~use_ser & gpib_rx_i.eoi;
  wire logic rx_lf = (rx_char == rcp_pkg::RCP_LF);
  wire logic rx_term = rx_lf | rx_eoi;
  wire logic rx_store = rx_take & ~rx_lf;

  // decoder, shared by both ports
  wire logic parse_end = (rd_q == wr_q);
  wire logic [7:0] pc = buf_mem[rd_q[4:0]];
  wire logic is_upper = (pc >= rcp_pkg::RCP_CH_A) && (pc <= rcp_pkg::RCP_CH_Z);
  wire logic is_digit = (pc >= rcp_pkg::RCP_CH_0) && (pc <= rcp_pkg::RCP_CH_9);
  wire logic is_q = (pc == rcp_pkg::RCP_QMARK);
  wire logic is_eq = (pc == rcp_pkg::RCP_EQUALS);
  wire logic mn_empty = (mn_cnt_q == 3'h0);
  wire logic mn_ok = is_upper | (is_digit & ~mn_empty);
  wire logic mn_full = (mn_cnt_q == rcp_pkg::RCP_MN_MAX);
  wire logic [19:0] arg_next = 20'(cmd_q.arg) * rcp_pkg::RCP_TEN + 20'(pc - rcp_pkg::RCP_CH_0);
  wire logic arg_ovf = (arg_next > rcp_pkg::RCP_ARG_MAX);

  logic char_bad;
  always_comb begin
    char_bad = 1'b0;
    case (ph_q)
      // lower case, spaces and stray symbols all land here
      rcp_pkg::RCP_PH_MNEM: char_bad = ~(mn_ok | is_q | is_eq) | (mn_ok & mn_full)
                                       | ((is_q | is_eq) & mn_empty);
      rcp_pkg::RCP_PH_QUERY: char_bad = ~is_eq;
      rcp_pkg::RCP_PH_ARGS: char_bad = ~is_digit | arg_ovf;
      default: char_bad = 1'b1;
    endcase
  end

  logic [rcp_pkg::RCP_NUM_CMDS-1:0] mn_hit;
  genvar gi;
  generate
    for (gi = 0; gi < rcp_pkg::RCP_NUM_CMDS; gi++) begin : g_lookup
      assign mn_hit[gi] = (mn_q == rcp_pkg::RCP_MN_TABLE[gi]);
    end
  endgenerate

  logic [2:0] hit_idx;
  always_comb begin
    hit_idx = 3'h0;
    for (int i = rcp_pkg::RCP_NUM_CMDS - 1; i >= 0; i--) begin
      if (mn_hit[i]) begin
        hit_idx = 3'(i);
      end
    end
  end
  wire logic known = |mn_hit;
  wire logic end_bad = ~known | ((ph_q == rcp_pkg::RCP_PH_ARGS) & ~cmd_q.has_arg)
                       | ovf_q;
  wire logic parse_fail = parse_end ? end_bad : char_bad;

  // reply sequencing: code or query text, then line feed
  // a parse error or a failing executor result both answer with the error code
  wire logic reply_err = err_q | res_q.err;
  wire logic [3:0] body_len = (reply_err | ~cmd_q.query) ? rcp_pkg::RCP_CODE_LEN : res_q.len;
  wire logic at_lf = (tx_idx_q >= body_len);
  wire logic [7:0] q_byte = res_q.data[8 * (7 - 32'(tx_idx_q[2:0])) +: 8];
  wire logic [7:0] body_char = reply_err ? rcp_pkg::RCP_ERR_CHAR
                             : (cmd_q.query ? q_byte
                                : rcp_pkg::RCP_ACK_CHAR);
  wire logic [7:0] reply_char = at_lf ? rcp_pkg::RCP_LF : body_char;
  wire logic tx_load = (state_q == RCP_REPLY) & ~tx_valid_q & ~last_q;
  wire logic tx_fire = tx_valid_q & tx_ready_i;

  always_comb begin
    state_d = state_q;
    case (state_q)
      RCP_COLLECT: if (rx_take & rx_term) state_d = RCP_PARSE;
      RCP_PARSE: if (parse_fail) state_d = RCP_REPLY;
                 else if (parse_end) state_d = RCP_EXEC;
      RCP_EXEC: if (exec_done_i) state_d = RCP_REPLY;
      RCP_REPLY: if (tx_fire & last_q) state_d = RCP_COLLECT;
      default: state_d = RCP_COLLECT;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) state_q <= RCP_COLLECT;
    else state_q <= state_d;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) rx_ready_q <= 1'b0;
    else rx_ready_q <= (state_d == RCP_COLLECT);
  end

  // line buffer; memory needs no reset
  always_ff @(posedge clk_i) begin
    if (rx_store && wr_q != rcp_pkg::RCP_BUF_FULL) buf_mem[wr_q[4:0]] <= rx_char;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_q <= 6'h00;
      ovf_q <= 1'b0;
      from_gpib_q <= 1'b0;
    end else if (state_q == RCP_REPLY && state_d == RCP_COLLECT) begin
      wr_q <= 6'h00;
      ovf_q <= 1'b0;
    end else if (rx_store) begin
      // an overlong line is kept as an error rather than silently cut
      if (wr_q == rcp_pkg::RCP_BUF_FULL) ovf_q <= 1'b1;
      else wr_q <= wr_q + 6'h01;
      from_gpib_q <= ~use_ser;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_q <= 6'h00;
      ph_q <= rcp_pkg::RCP_PH_MNEM;
      mn_q <= 32'h00000000;
      mn_cnt_q <= 3'h0;
      err_q <= 1'b0;
      cmd_q <= '0;
    end else if (state_q == RCP_COLLECT) begin
      rd_q <= 6'h00;
      ph_q <= rcp_pkg::RCP_PH_MNEM;
      mn_q <= 32'h00000000;
      mn_cnt_q <= 3'h0;
      err_q <= 1'b0;
      cmd_q <= '0;
    end else if (state_q == RCP_PARSE) begin
      if (parse_fail) err_q <= 1'b1;
      else if (parse_end) cmd_q.cmd <= hit_idx;
      else begin
        rd_q <= rd_q + 6'h01;
        case (ph_q)
          rcp_pkg::RCP_PH_MNEM: begin
            if (is_q) begin
              cmd_q.query <= 1'b1;
              ph_q <= rcp_pkg::RCP_PH_QUERY;
            end else if (is_eq) ph_q <= rcp_pkg::RCP_PH_ARGS;
            else begin
              mn_q <= {mn_q[23:0], pc};
              mn_cnt_q <= mn_cnt_q + 3'h1;
            end
          end
          rcp_pkg::RCP_PH_QUERY: ph_q <= rcp_pkg::RCP_PH_ARGS;
          default: begin
            cmd_q.arg <= arg_next[15:0];
            cmd_q.has_arg <= 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      exec_valid_q <= 1'b0;
      res_q <= '0;
    end else begin
      exec_valid_q <= (state_d == RCP_EXEC);
      if (state_q == RCP_EXEC && exec_done_i) res_q <= exec_res_i;
    end
  end

  // the executor's error verdict folds into the reply code
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_valid_q <= 1'b0;
      tx_data_q <= 8'h00;
      tx_idx_q <= 4'h0;
      last_q <= 1'b0;
    end else if (state_q != RCP_REPLY) begin
      tx_idx_q <= 4'h0;
      last_q <= 1'b0;
    end else if (tx_load) begin
      tx_valid_q <= 1'b1;
      tx_data_q <= reply_char;
      tx_idx_q <= tx_idx_q + 4'h1;
      last_q <= at_lf;
    end else if (tx_fire) tx_valid_q <= 1'b0;
  end

  assign rx_ready_o = rx_ready_q;
  assign tx_valid_o = tx_valid_q;
  assign tx_data_o = tx_data_q;
  assign tx_gpib_o = from_gpib_q;
  assign exec_valid_o = exec_valid_q;
  assign exec_cmd_o = cmd_q;

  ser_term_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rx_take && use_ser && rx_lf |=> state_q == RCP_PARSE)
    else $error("serial line feed did not end the command");
  gpib_eoi_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rx_take && !use_ser && gpib_rx_i.eoi |=> state_q == RCP_PARSE ##1 rd_q <= wr_q)
    else $error("gpib eoi did not end the command");
  no_early_parse_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    state_q == RCP_COLLECT && !(rx_take && rx_term) |=> state_q == RCP_COLLECT)
    else $error("parsing began without a terminator");
  reply_lf_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    tx_valid_q && last_q |-> tx_data_q == rcp_pkg::RCP_LF)
    else $error("reply did not end in line feed");
  err_code_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    tx_valid_q && err_q && !last_q |-> tx_data_q == rcp_pkg::RCP_ERR_CHAR)
    else $error("error reply is not code 55");
  ack_code_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    tx_valid_q && !reply_err && !cmd_q.query && !last_q |-> tx_data_q == rcp_pkg::RCP_ACK_CHAR)
    else $error("configuration reply is not code 00");
  exec_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    exec_valid_q && !exec_done_i |=> exec_valid_q && $stable(cmd_q))
    else $error("command changed while awaiting execution");
  busy_block_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rx_ready_q |-> state_q == RCP_COLLECT)
    else $error("receiver open while a command is pending");
  query_start_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    state_q == RCP_EXEC && exec_done_i |=> state_q == RCP_REPLY ##1 tx_valid_q)
    else $error("query answer not started");
  unknown_err_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    state_q == RCP_PARSE && parse_end && !known |=> err_q && state_q == RCP_REPLY)
    else $error("unknown mnemonic not flagged as error");
  upper_only_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    state_q == RCP_PARSE && !parse_end && ph_q == rcp_pkg::RCP_PH_MNEM
    && !(is_upper || is_digit || is_q || is_eq) |=> err_q)
    else $error("illegal character accepted in mnemonic");
  exec_err_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    tx_valid_q && res_q.err && !last_q |-> tx_data_q == rcp_pkg::RCP_ERR_CHAR)
    else $error("failed execution did not answer with code 55");
  rx_close_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rx_take && rx_term |=> !rx_ready_q)
    else $error("receiver stayed open after a terminator");
  parse_skip_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    state_q == RCP_PARSE && parse_fail |=> state_q == RCP_REPLY && !exec_valid_q)
    else $error("malformed command reached the executor");

  query_cov_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
    tx_fire && last_q && cmd_q.query && !err_q);
  config_cov_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
    tx_fire && last_q && !cmd_q.query && !err_q);
  error_cov_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
    tx_fire && last_q && err_q);
  exec_err_cov_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
    tx_fire && last_q && res_q.err && !err_q);
endmodule // rcp_parser

`default_nettype wire

// [rcp_pkg.sv]
// constants and types shared by the remote command parser
package rcp_pkg;
  // ascii characters the parser reacts to
  localparam logic [7:0] RCP_LF = 8'h0A;
  localparam logic [7:0] RCP_QMARK = 8'h3F;
  localparam logic [7:0] RCP_EQUALS = 8'h3D;
  localparam logic [7:0] RCP_CH_A = 8'h41;
  localparam logic [7:0] RCP_CH_Z = 8'h5A;
  localparam logic [7:0] RCP_CH_0 = 8'h30;
  localparam logic [7:0] RCP_CH_9 = 8'h39;
  // reply codes are sent as two ascii hex digits
  localparam logic [7:0] RCP_ACK_CHAR = 8'h30;
  localparam logic [7:0] RCP_ERR_CHAR = 8'h35;
  localparam logic [3:0] RCP_CODE_LEN = 4'h2;
  // command line buffer
  localparam int RCP_BUF_DEPTH = 32;
  localparam logic [5:0] RCP_BUF_FULL = 6'h20;
  localparam int RCP_MN_CHARS = 4;
  localparam logic [2:0] RCP_MN_MAX = 3'h4;
  localparam int RCP_NUM_CMDS = 8;
  localparam int RCP_QDATA_BYTES = 8;
  localparam logic [19:0] RCP_ARG_MAX = 20'h0FFFF;
  localparam logic [19:0] RCP_TEN = 20'h0000A;
  // known mnemonics, right justified ascii, zero padded
  localparam logic [31:0] RCP_MN_TABLE [RCP_NUM_CMDS] = '{
    32'h00004944, 32'h41444452, 32'h43415244, 32'h54595045,
    32'h4348414E, 32'h4741494E, 32'h46524551, 32'h534C4F54};

  typedef enum logic [1:0] {
    RCP_PH_MNEM,
    RCP_PH_QUERY,
    RCP_PH_ARGS
  } rcp_phase_type;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic eoi;
  } rcp_rxch_type;

  typedef struct packed {
    logic [2:0] cmd;
    logic query;
    logic has_arg;
    logic [15:0] arg;
  } rcp_cmd_type;

  typedef struct packed {
    logic err;
    logic [3:0] len;
    logic [63:0] data;
  } rcp_result_type;
endpackage

// [rcp_host_model.sv]
// remote host model: sends command lines on either port and collects the reply
`timescale 1ns/1ps
`default_nettype none
module rcp_host_model (
  input wire logic clk_i,
  input wire logic rx_ready_i,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  input wire logic slow_i,
  output var rcp_pkg::rcp_rxch_type ser_rx_o,
  output var rcp_pkg::rcp_rxch_type gpib_rx_o,
  output var logic tx_ready_o,
  output var logic sending_o
);
  // the link has data and reply ready only, no rts or dtr hold-off
  initial begin
    ser_rx_o = '0;
    gpib_rx_o = '0;
    tx_ready_o = 1'b0;
    sending_o = 1'b0;
  end

  // only one port carries a character at a time
  task automatic put(input logic [7:0] c, input bit gpib, input bit eoi);
    @(posedge clk_i);
    ser_rx_o <= '{valid: !gpib, data: c, eoi: 1'b0};
    gpib_rx_o <= '{valid: gpib, data: c, eoi: eoi};
  endtask

  // term: 0 none (aborted line), 1 line feed, 2 eoi on the last gpib char
  task automatic cmd(input string s, input bit gpib, input int term,
                     output logic [127:0] rep);
    int n;
    rep = '0;
    n = 0;
    while (!rx_ready_i && n < 500) begin
      @(posedge clk_i);
      n++;
    end
    sending_o <= 1'b1;
    for (int i = 0; i < s.len(); i++) begin
      put(s[i], gpib, term == 2 && i == s.len() - 1);
    end
    if (term == 1) begin
      put(rcp_pkg::RCP_LF, gpib, 1'b0);
    end
    @(posedge clk_i);
    // released lines carry junk so a stale char can never be mistaken for data
    ser_rx_o <= '{valid: 1'b0, data: ~ser_rx_o.data, eoi: 1'b0};
    gpib_rx_o <= '{valid: 1'b0, data: ~gpib_rx_o.data, eoi: 1'b0};
    sending_o <= 1'b0;
    n = (term == 0) ? 500 : 0;
    while (n < 500) begin
      @(posedge clk_i);
      if (tx_valid_i && tx_ready_o) begin
        rep = {rep[119:0], tx_data_i};
        if (tx_data_i == rcp_pkg::RCP_LF) begin
          n = 500;
        end
      end
      tx_ready_o <= (n < 500) && (slow_i ? ~tx_ready_o : 1'b1);
      n++;
    end
  endtask
endmodule // rcp_host_model
`default_nettype wire

// [rcp_parser_test.sv]
// self-checking bench of the remote command parser
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; \
  $display("Error t=%0t got %0h exp %0h", $time, (a), (b)); end end
module rcp_parser_test;
  typedef struct {
    string s;
    logic g;
    int term;
    int kind;
    logic [2:0] idx;
    logic q;
    logic ha;
    logic [15:0] arg;
  } rcp_row_type;

  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic slow = 1'b0;
  logic sending;
  rcp_pkg::rcp_rxch_type ser_rx_i;
  rcp_pkg::rcp_rxch_type gpib_rx_i;
  logic rx_ready_o;
  logic tx_valid_o;
  logic [7:0] tx_data_o;
  logic tx_gpib_o;
  logic tx_ready_i;
  logic exec_valid_o;
  rcp_pkg::rcp_cmd_type exec_cmd_o;
  logic exec_done_i = 1'b0;
  rcp_pkg::rcp_result_type exec_res_i = '0;
  rcp_pkg::rcp_cmd_type got_cmd;
  int failures = 0;
  int samples_checked = 0;
  int lat = 0;
  int cnt = 0;
  int exec_n = 0;
  logic served = 1'b0;
  logic exe_err = 1'b0;
  logic [127:0] rep;
  // kind: 0 configuration, 1 query, 2 refused, 3 executor failure
  rcp_row_type rows [13] = '{
    '{"ID?", 0, 1, 1, 3'h0, 1, 0, 16'h0000},
    '{"ADDR=12", 1, 1, 0, 3'h1, 0, 1, 16'h000C},
    '{"ADDR=12", 0, 1, 0, 3'h1, 0, 1, 16'h000C},
    '{"CARD?", 1, 2, 1, 3'h2, 1, 0, 16'h0000},
    '{"TYPE?=7", 0, 1, 1, 3'h3, 1, 1, 16'h0007},
    '{"CHAN=65535", 0, 1, 0, 3'h4, 0, 1, 16'hFFFF},
    '{"GAIN=0", 1, 1, 0, 3'h5, 0, 1, 16'h0000},
    '{"GAIN=65536", 0, 1, 2, 3'h5, 0, 1, 16'h0000},
    '{"FREQ=", 1, 1, 2, 3'h6, 0, 0, 16'h0000},
    '{"SLOT?", 1, 2, 1, 3'h7, 1, 0, 16'h0000},
    '{"XYZ?", 0, 1, 2, 3'h0, 0, 0, 16'h0000},
    '{"ID=1,2", 1, 2, 2, 3'h0, 0, 0, 16'h0000},
    '{"id?", 0, 1, 2, 3'h0, 0, 0, 16'h0000}};

  always #2 clk_i = ~clk_i;

  rcp_parser i_rcp_parser (.clk_i(clk_i), .resetn_i(resetn_i), .ser_rx_i(ser_rx_i),
    .gpib_rx_i(gpib_rx_i), .rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o),
    .tx_data_o(tx_data_o), .tx_gpib_o(tx_gpib_o), .tx_ready_i(tx_ready_i),
    .exec_valid_o(exec_valid_o), .exec_cmd_o(exec_cmd_o), .exec_done_i(exec_done_i),
    .exec_res_i(exec_res_i));

  rcp_host_model i_rcp_host_model (.clk_i(clk_i), .rx_ready_i(rx_ready_o),
    .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .slow_i(slow), .ser_rx_o(ser_rx_i),
    .gpib_rx_o(gpib_rx_i), .tx_ready_o(tx_ready_i), .sending_o(sending));

  // executor: answers after lat cycles, query text is Q and the command index
  always @(posedge clk_i) begin
    exec_done_i <= 1'b0;
    if (!exec_valid_o) begin
      served <= 1'b0;
      cnt <= 0;
    end else if (!served) begin
      if (cnt == 0) `CHK(sending, 1'b0)
      if (cnt >= lat) begin
        exec_done_i <= 1'b1;
        exec_res_i <= '{err: exe_err, len: exec_cmd_o.query ? 4'h2 : 4'h0,
          data: {8'h51, 8'h30 + {5'h00, exec_cmd_o.cmd}, 48'h0}};
        got_cmd <= exec_cmd_o;
        served <= 1'b1;
        exec_n <= exec_n + 1;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end

  function automatic logic [127:0] pack(input string s);
    logic [127:0] v;
    v = '0;
    for (int i = 0; i < s.len(); i++) v = {v[119:0], s[i]};
    return v;
  endfunction

  task automatic run(input rcp_row_type r);
    string e;
    int n0;
    n0 = exec_n;
    e = (r.kind == 0) ? "00\n" : (r.kind == 1) ? "Q0\n" : "55\n";
    if (r.kind == 1) e[1] = 8'h30 + {5'h00, r.idx};
    i_rcp_host_model.cmd(r.s, r.g, r.term, rep);
    `CHK(rep, pack(e))
    `CHK(exec_n - n0, (r.kind == 2) ? 0 : 1)
    `CHK(tx_gpib_o, r.g)
    if (r.kind != 2) `CHK(got_cmd, rcp_pkg::rcp_cmd_type'({r.idx, r.q, r.ha, r.arg}))
  endtask

  task automatic do_reset();
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    `CHK({rx_ready_o, tx_valid_o, exec_valid_o, tx_gpib_o, tx_data_o, exec_cmd_o}, 33'h0)
    resetn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1 `CHK(rx_ready_o, 1'b1)
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    failures++;
    conclude();
  end

  initial begin
    do_reset();
    foreach (rows[i]) run(rows[i]);
    // a line longer than the 32 char buffer is refused
    run('{"ID?012345678901234567890123456789", 0, 1, 2, 3'h0, 0, 0, 16'h0000});
    // slow executor and a stalling reader on the reply
    lat = 20;
    slow = 1'b1;
    run('{"FREQ?", 1, 2, 1, 3'h6, 1, 0, 16'h0000});
    lat = 0;
    slow = 1'b0;
    // executor reports a failure: the reply is the error code
    exe_err = 1'b1;
    run('{"CHAN=5", 0, 1, 3, 3'h4, 0, 1, 16'h0005});
    exe_err = 1'b0;
    // a half sent line is dropped by reset and never executed
    i_rcp_host_model.cmd("ADDR=1", 0, 0, rep);
    repeat (40) @(posedge clk_i);
    `CHK(exec_valid_o, 1'b0)
    do_reset();
    run(rows[0]);
    conclude();
  end
endmodule // rcp_parser_test
`default_nettype wire
